// ==== include/btcl_defs.svh ====
`ifndef BTCL_DEFS_SVH
`define BTCL_DEFS_SVH

// Register byte offsets
`define BTCL_OFS_CTRL 12'h000
`define BTCL_OFS_CMPA 12'h004
`define BTCL_OFS_CMPB 12'h008
`define BTCL_OFS_STAT 12'h00C
`define BTCL_OFS_FIFO 12'h010

// Control word fields
`define BTCL_CTRL_MODE_LSB 0
`define BTCL_CTRL_RWEN_BIT 4
`define BTCL_CTRL_RWVAL_BIT 5
`define BTCL_CTRL_BRK_BIT 6
`define BTCL_CTRL_TAG_BIT 7
`define BTCL_CTRL_START_BIT 8

// Reset values
`define BTCL_CTRL_RST 8'h00
`define BTCL_CMP_RST 16'h0000

// Capture store geometry and readout flag
`define BTCL_FIFO_AW 3
`define BTCL_FIFO_EMPTY_BIT 8

// Bus answers
`define BTCL_RESP_OKAY 2'h0
`define BTCL_RESP_SLVERR 2'h2

`endif

// ==== include/btcl_pkg.sv ====
package btcl_pkg;

   typedef enum logic [3:0] {
      BTCL_A_ONLY      = 4'h0,
      BTCL_A_OR_B      = 4'h1,
      BTCL_A_THEN_B    = 4'h2,
      BTCL_EVT_B       = 4'h3,
      BTCL_A_THEN_EVT_B = 4'h4,
      BTCL_INSIDE      = 4'h5,
      BTCL_OUTSIDE     = 4'h6,
      BTCL_A_AND_D     = 4'h7,
      BTCL_A_NOT_D     = 4'h8
   } btcl_mode_t;

   // Gray along idle, run, armed, done
   typedef enum logic [1:0] {
      BTCL_IDLE  = 2'h0,
      BTCL_RUN   = 2'h1,
      BTCL_ARMED = 2'h3,
      BTCL_DONE  = 2'h2
   } btcl_state_t;

   typedef struct packed {
      logic tag;
      logic cpu_break_enable;
      logic rw_match_value;
      logic rw_check_enable;
      btcl_mode_t mode;
   } btcl_ctrl_t;

   typedef struct packed {
      logic valid;
      logic rw;
      logic [15:0] addr;
      logic [7:0] data;
   } btcl_bus_t;

endpackage

// ==== rtl/btcl_fifo.sv ====
`timescale 1ns/10ps
`include "btcl_defs.svh"

module btcl_fifo (
   // Clock and reset
   input logic aclk,
   input logic aresetn,
   // Fill side
   input logic clr,
   input logic push,
   input logic [7:0] din,
   // Drain side
   input logic pop,
   output logic [7:0] dout,
   // Level
   output logic full,
   output logic empty,
   output logic [`BTCL_FIFO_AW:0] count
);

   localparam int DEPTH = 1 << `BTCL_FIFO_AW;

   logic [7:0] mem_r [DEPTH];
   logic [`BTCL_FIFO_AW-1:0] wr_ptr_r;
   logic [`BTCL_FIFO_AW-1:0] rd_ptr_r;
   logic [`BTCL_FIFO_AW:0] cnt_r;
   logic push_ok;
   logic pop_ok;

   // Push when full is dropped, never overwrites
   assign push_ok = push & ~full;
   assign pop_ok = pop & ~empty;
   assign full = (cnt_r == (`BTCL_FIFO_AW+1)'(DEPTH));
   assign empty = (cnt_r == '0);
   assign count = cnt_r;
   assign dout = mem_r[rd_ptr_r];

   always_ff @(posedge aclk) begin
      if (push_ok) begin
         mem_r[wr_ptr_r] <= din;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn || clr) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
      end else begin
         if (push_ok) begin
            wr_ptr_r <= wr_ptr_r + 1'b1;
         end
         if (pop_ok) begin
            rd_ptr_r <= rd_ptr_r + 1'b1;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn || clr) begin
         cnt_r <= '0;
      end else if (push_ok && !pop_ok) begin
         cnt_r <= cnt_r + 1'b1;
      end else if (pop_ok && !push_ok) begin
         cnt_r <= cnt_r - 1'b1;
      end
   end

endmodule

// ==== rtl/btcl_trigger.sv ====
// Implementation choices: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/10ps
`include "btcl_defs.svh"

// Contract
// - A-only mode: trigger when address equals A
// - Either mode: address equals A or B
// - A arms; later B match triggers
// - Full mode: A address, B data, direction
// - Tag break in full modes: A only
// - Full not-data mode: A, data differs, direction
// - Event B: each B match captured, stop full
// - After A, each B match captured, stop full
// - Inside range: A <= address <= B
// - Outside range: below A or above B

module btcl_trigger (
   // Clock and reset
   input logic aclk,
   input logic aresetn,
   // Register bus write
   input logic [11:0] s_axi_awaddr,
   input logic s_axi_awvalid,
   output logic s_axi_awready,
   input logic [31:0] s_axi_wdata,
   input logic [3:0] s_axi_wstrb,
   input logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input logic s_axi_bready,
   // Register bus read
   input logic [11:0] s_axi_araddr,
   input logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input logic s_axi_rready,
   // Watched core bus
   input btcl_pkg::btcl_bus_t core_bus,
   // Trigger and breakpoint
   output logic trigger_out,
   output logic cpu_break_req,
   output logic cpu_break_tag,
   output logic run_active
);

   btcl_pkg::btcl_ctrl_t ctrl_r;
   btcl_pkg::btcl_state_t state_r;
   btcl_pkg::btcl_state_t state_nxt;
   logic [15:0] cmpa_r;
   logic [15:0] cmpb_r;
   logic [31:0] ctrl_wv;
   logic [31:0] cmpa_wv;
   logic [31:0] cmpb_wv;
   logic [31:0] rd_mux;
   logic wr_go;
   logic rd_go;
   logic start_pulse;
   logic a_hit;
   logic b_hit;
   logic d_hit;
   logic rw_ok;
   logic in_rng;
   logic out_rng;
   logic hit;
   logic trig;
   logic running;
   logic armed;
   logic seq_mode;
   logic store_mode;
   logic full_mode;
   logic tag_hit;
   logic trig_seen_r;
   logic fifo_push;
   logic fifo_pop;
   logic fifo_full;
   logic fifo_empty;
   logic [`BTCL_FIFO_AW:0] fifo_cnt;
   logic [7:0] fifo_dout;

   function automatic logic addr_eq(input logic [15:0] x,
                                    input logic [15:0] y);
      return x == y;
   endfunction

   function automatic logic addr_mapped(input logic [11:0] a);
      return a == `BTCL_OFS_CTRL || a == `BTCL_OFS_CMPA ||
             a == `BTCL_OFS_CMPB || a == `BTCL_OFS_STAT ||
             a == `BTCL_OFS_FIFO;
   endfunction

   function automatic logic [31:0] lane_merge(input logic [31:0] old,
                                              input logic [31:0] nw,
                                              input logic [3:0] strb);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return res;
   endfunction

   // Write takes address and data together
   assign wr_go = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
   assign s_axi_awready = wr_go;
   assign s_axi_wready = wr_go;
   assign rd_go = s_axi_arvalid & ~s_axi_rvalid;
   assign s_axi_arready = rd_go;

   assign ctrl_wv = lane_merge({24'h000000, ctrl_r}, s_axi_wdata,
                               s_axi_wstrb);
   assign cmpa_wv = lane_merge({16'h0000, cmpa_r}, s_axi_wdata,
                               s_axi_wstrb);
   assign cmpb_wv = lane_merge({16'h0000, cmpb_r}, s_axi_wdata,
                               s_axi_wstrb);

   // Start is a self-clearing strobe, never stored
   assign start_pulse = wr_go && s_axi_awaddr == `BTCL_OFS_CTRL &&
                        s_axi_wstrb[1] &&
                        s_axi_wdata[`BTCL_CTRL_START_BIT];

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_r <= btcl_pkg::btcl_ctrl_t'(`BTCL_CTRL_RST);
      end else if (wr_go && s_axi_awaddr == `BTCL_OFS_CTRL) begin
         ctrl_r <= btcl_pkg::btcl_ctrl_t'(ctrl_wv[7:0]);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cmpa_r <= `BTCL_CMP_RST;
      end else if (wr_go && s_axi_awaddr == `BTCL_OFS_CMPA) begin
         cmpa_r <= cmpa_wv[15:0];
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cmpb_r <= `BTCL_CMP_RST;
      end else if (wr_go && s_axi_awaddr == `BTCL_OFS_CMPB) begin
         cmpb_r <= cmpb_wv[15:0];
      end
   end

   // Read-only offsets accept writes silently
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `BTCL_RESP_OKAY;
      end else if (wr_go) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= addr_mapped(s_axi_awaddr) ?
                        `BTCL_RESP_OKAY : `BTCL_RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   always_comb begin
      rd_mux = 32'h00000000;
      case (s_axi_araddr)
         `BTCL_OFS_CTRL: rd_mux = {24'h000000, ctrl_r};
         `BTCL_OFS_CMPA: rd_mux = {16'h0000, cmpa_r};
         `BTCL_OFS_CMPB: rd_mux = {16'h0000, cmpb_r};
         `BTCL_OFS_STAT: begin
            rd_mux = {20'h00000, fifo_cnt, 2'h0, trig_seen_r,
                      fifo_empty, fifo_full,
                      state_r == btcl_pkg::BTCL_DONE, armed, running};
         end
         `BTCL_OFS_FIFO: begin
            rd_mux = {24'h000000, fifo_dout};
            rd_mux[`BTCL_FIFO_EMPTY_BIT] = fifo_empty;
         end
         default: rd_mux = 32'h00000000;
      endcase
   end

   // Reading the capture word consumes it
   assign fifo_pop = rd_go && s_axi_araddr == `BTCL_OFS_FIFO &&
                     !fifo_empty;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `BTCL_RESP_OKAY;
      end else if (rd_go) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_mux;
         s_axi_rresp <= addr_mapped(s_axi_araddr) ?
                        `BTCL_RESP_OKAY : `BTCL_RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // Comparators
   assign a_hit = core_bus.valid && addr_eq(core_bus.addr, cmpa_r);
   assign b_hit = core_bus.valid && addr_eq(core_bus.addr, cmpb_r);
   // Upper byte of B is ignored for data
   assign d_hit = core_bus.data == cmpb_r[7:0];
   assign rw_ok = !ctrl_r.rw_check_enable ||
                  core_bus.rw == ctrl_r.rw_match_value;
   assign in_rng = core_bus.valid && core_bus.addr >= cmpa_r &&
                   core_bus.addr <= cmpb_r;
   assign out_rng = core_bus.valid && (core_bus.addr < cmpa_r ||
                    core_bus.addr > cmpb_r);

   assign running = state_r == btcl_pkg::BTCL_RUN ||
                    state_r == btcl_pkg::BTCL_ARMED;
   assign armed = state_r == btcl_pkg::BTCL_ARMED;
   assign seq_mode = ctrl_r.mode == btcl_pkg::BTCL_A_THEN_B ||
                     ctrl_r.mode == btcl_pkg::BTCL_A_THEN_EVT_B;
   assign store_mode = ctrl_r.mode == btcl_pkg::BTCL_EVT_B ||
                       ctrl_r.mode == btcl_pkg::BTCL_A_THEN_EVT_B;
   assign full_mode = ctrl_r.mode == btcl_pkg::BTCL_A_AND_D ||
                      ctrl_r.mode == btcl_pkg::BTCL_A_NOT_D;

   always_comb begin
      hit = 1'b0;
      case (ctrl_r.mode)
         btcl_pkg::BTCL_A_ONLY: hit = a_hit;
         btcl_pkg::BTCL_A_OR_B: hit = a_hit || b_hit;
         btcl_pkg::BTCL_A_THEN_B: hit = armed && b_hit;
         btcl_pkg::BTCL_EVT_B: hit = b_hit;
         btcl_pkg::BTCL_A_THEN_EVT_B: hit = armed && b_hit;
         btcl_pkg::BTCL_INSIDE: hit = in_rng;
         btcl_pkg::BTCL_OUTSIDE: hit = out_rng;
         btcl_pkg::BTCL_A_AND_D: hit = a_hit && d_hit && rw_ok;
         btcl_pkg::BTCL_A_NOT_D: hit = a_hit && !d_hit && rw_ok;
         default: hit = 1'b0;
      endcase
   end

   // A full store drops further events instead of overwriting
   assign trig = running && hit && !(store_mode && fifo_full);
   assign fifo_push = trig && store_mode;
   // Tag request ignores the data result in full modes
   assign tag_hit = full_mode ? (running && a_hit) : trig;

   always_comb begin
      state_nxt = state_r;
      case (state_r)
         btcl_pkg::BTCL_IDLE: state_nxt = state_r;
         btcl_pkg::BTCL_RUN: begin
            // Full store ends the run even before arming
            if (store_mode && fifo_full) begin
               state_nxt = btcl_pkg::BTCL_DONE;
            end else if (seq_mode && a_hit) begin
               state_nxt = btcl_pkg::BTCL_ARMED;
            end else if (trig && !store_mode) begin
               state_nxt = btcl_pkg::BTCL_DONE;
            end
         end
         btcl_pkg::BTCL_ARMED: begin
            if (trig && !store_mode) begin
               state_nxt = btcl_pkg::BTCL_DONE;
            end else if (store_mode && fifo_full) begin
               state_nxt = btcl_pkg::BTCL_DONE;
            end
         end
         btcl_pkg::BTCL_DONE: state_nxt = state_r;
         default: state_nxt = btcl_pkg::BTCL_IDLE;
      endcase
      if (start_pulse) begin
         state_nxt = btcl_pkg::BTCL_RUN;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_r <= btcl_pkg::BTCL_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   // Outputs lag the watched bus cycle by one clock
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         trigger_out <= 1'b0;
         cpu_break_req <= 1'b0;
      end else begin
         trigger_out <= trig;
         cpu_break_req <= ctrl_r.cpu_break_enable &&
                          (ctrl_r.tag ? tag_hit : trig);
      end
   end

   assign cpu_break_tag = ctrl_r.tag;
   assign run_active = running;

   // Set wins over the restart clear
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         trig_seen_r <= 1'b0;
      end else if (trig) begin
         trig_seen_r <= 1'b1;
      end else if (start_pulse) begin
         trig_seen_r <= 1'b0;
      end
   end

   btcl_fifo u_fifo (
      .aclk(aclk),
      .aresetn(aresetn),
      .clr(start_pulse),
      .push(fifo_push),
      .din(core_bus.data),
      .pop(fifo_pop),
      .dout(fifo_dout),
      .full(fifo_full),
      .empty(fifo_empty),
      .count(fifo_cnt)
   );

   a_a_only_hit: assert property (
      @(posedge aclk) disable iff (!aresetn)
      running && ctrl_r.mode == btcl_pkg::BTCL_A_ONLY &&
      core_bus.valid && core_bus.addr == cmpa_r |=> trigger_out)
      else $error("A-only address match gave no trigger");

   a_either_hit: assert property (
      @(posedge aclk) disable iff (!aresetn)
      running && ctrl_r.mode == btcl_pkg::BTCL_A_OR_B &&
      core_bus.valid && core_bus.addr == cmpb_r |=> trigger_out)
      else $error("Either mode missed a B match");

   a_seq_order: assert property (
      @(posedge aclk) disable iff (!aresetn)
      trigger_out && $past(seq_mode) |-> $past(armed))
      else $error("Sequence trigger without prior A match");

   a_full_addr: assert property (
      @(posedge aclk) disable iff (!aresetn)
      ctrl_r.mode == btcl_pkg::BTCL_A_AND_D &&
      core_bus.addr != cmpa_r ##1 $stable(ctrl_r) |-> !trigger_out)
      else $error("Full mode triggered without A match");

   a_tag_break: assert property (
      @(posedge aclk) disable iff (!aresetn)
      running && full_mode && ctrl_r.tag &&
      ctrl_r.cpu_break_enable && a_hit |=> cpu_break_req)
      else $error("Tag break missing on A match in full mode");

   a_not_data: assert property (
      @(posedge aclk) disable iff (!aresetn)
      ctrl_r.mode == btcl_pkg::BTCL_A_NOT_D && d_hit
      |=> !trigger_out)
      else $error("Not-data mode triggered on equal data");

   a_full_stop: assert property (
      @(posedge aclk) disable iff (!aresetn)
      running && store_mode && fifo_full && !start_pulse
      |-> !fifo_push ##1 state_r == btcl_pkg::BTCL_DONE)
      else $error("Store run continued with full capture");

   a_store_armed: assert property (
      @(posedge aclk) disable iff (!aresetn)
      fifo_push && ctrl_r.mode == btcl_pkg::BTCL_A_THEN_EVT_B
      |-> armed && b_hit)
      else $error("Capture before A match in sequence store");

   a_inside_rng: assert property (
      @(posedge aclk) disable iff (!aresetn)
      running && ctrl_r.mode == btcl_pkg::BTCL_INSIDE &&
      core_bus.valid && core_bus.addr >= cmpa_r &&
      core_bus.addr <= cmpb_r |=> trigger_out)
      else $error("Inside range address gave no trigger");

   a_outside_rng: assert property (
      @(posedge aclk) disable iff (!aresetn)
      ctrl_r.mode == btcl_pkg::BTCL_OUTSIDE &&
      core_bus.addr >= cmpa_r && core_bus.addr <= cmpb_r
      |=> !trigger_out)
      else $error("Outside mode triggered inside range");

   a_idle_quiet: assert property (
      @(posedge aclk) disable iff (!aresetn)
      trigger_out |-> $past(running))
      else $error("Trigger raised while not running");

endmodule

// ==== verif/btcl_core_model.sv ====
`timescale 1ns/10ps

// Stand-in for the watched processor bus
module btcl_core_model (
   // Clock
   input logic aclk,
   // Watched bus
   output btcl_pkg::btcl_bus_t core_bus
);
   initial begin
      core_bus = '0;
   end

   // One bus cycle, sampled by the block at the edge the task returns on
   task automatic drive(input logic [15:0] a, input logic [7:0] d,
                        input logic rw);
      @(posedge aclk);
      core_bus <= {1'b1, rw, a, d};
      @(posedge aclk);
      // Idle lines show inverted content so stale values never match
      core_bus <= {1'b0, ~rw, ~a, ~d};
   endtask
endmodule

// ==== verif/btcl_trigger_tb_top.sv ====
`timescale 1ns/10ps
`include "btcl_defs.svh"

module btcl_trigger_tb_top;
   logic aclk;
   logic aresetn;
   logic [11:0] s_axi_awaddr;
   logic s_axi_awvalid;
   logic s_axi_awready;
   logic [31:0] s_axi_wdata;
   logic [3:0] s_axi_wstrb;
   logic s_axi_wvalid;
   logic s_axi_wready;
   logic [1:0] s_axi_bresp;
   logic s_axi_bvalid;
   logic s_axi_bready;
   logic [11:0] s_axi_araddr;
   logic s_axi_arvalid;
   logic s_axi_arready;
   logic [31:0] s_axi_rdata;
   logic [1:0] s_axi_rresp;
   logic s_axi_rvalid;
   logic s_axi_rready;
   btcl_pkg::btcl_bus_t core_bus;
   logic trigger_out;
   logic cpu_break_req;
   logic cpu_break_tag;
   logic run_active;
   logic [31:0] rd_data;
   logic [1:0] rd_resp;
   int bad_count;
   int compares;
   int i;

   btcl_trigger btcl_trigger_i (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready), .core_bus(core_bus),
      .trigger_out(trigger_out), .cpu_break_req(cpu_break_req),
      .cpu_break_tag(cpu_break_tag), .run_active(run_active));

   btcl_core_model btcl_core_model_i (.aclk(aclk), .core_bus(core_bus));

   initial begin
      aclk = 1'b0;
      forever #2 aclk = ~aclk;
   end

   task check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         bad_count++;
         $display("Error at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask

   task end_of_test;
      $display("Compares %0d, mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // Ready is judged at the falling edge so the taking edge is race free
   task wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= 4'hF;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do @(negedge aclk);
      while (s_axi_awready !== 1'b1);
      @(posedge aclk);
      s_axi_awvalid <= 1'b0;
      s_axi_wvalid <= 1'b0;
      do @(negedge aclk);
      while (s_axi_bvalid !== 1'b1);
      // Response taken at the handshake edge, before it is released
      @(posedge aclk);
      check(s_axi_bresp, er);
      s_axi_bready <= 1'b0;
   endtask

   task rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(negedge aclk);
      while (s_axi_arready !== 1'b1);
      @(posedge aclk);
      s_axi_arvalid <= 1'b0;
      do @(negedge aclk);
      while (s_axi_rvalid !== 1'b1);
      @(posedge aclk);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask

   task rdc(input logic [11:0] a, input logic [31:0] exp);
      rd(a, rd_data, rd_resp);
      check(rd_data, exp);
      check(rd_resp, `BTCL_RESP_OKAY);
   endtask

   task cyc(input logic [15:0] a, input logic [7:0] d, input logic rw,
            input logic et, input logic eb);
      btcl_core_model_i.drive(a, d, rw);
      #1;
      check(trigger_out, et);
      check(cpu_break_req, eb);
   endtask

   // Fresh run per probe, since plain modes stop after one trigger
   task pb(input logic [3:0] m, input logic [3:0] nib, input logic [15:0] a,
           input logic [7:0] d, input logic rw, input logic et,
           input logic eb);
      wr(`BTCL_OFS_CTRL, {23'h0, 1'b1, nib, m}, `BTCL_RESP_OKAY);
      check(run_active, 1'b1);
      check(cpu_break_tag, nib[3]);
      cyc(a, d, rw, et, eb);
      check(run_active, !et);
   endtask

   // Cut a hang well past the expected run of a few hundred cycles
   initial begin
      repeat (30000) @(posedge aclk);
      bad_count++;
      end_of_test;
   end

   initial begin
      aresetn = 1'b0;
      {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb} = '0;
      {s_axi_wvalid, s_axi_bready, s_axi_araddr} = '0;
      {s_axi_arvalid, s_axi_rready} = '0;
      bad_count = 0;
      compares = 0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      rdc(`BTCL_OFS_CTRL, 32'h0);
      rdc(`BTCL_OFS_CMPA, 32'h0);
      rdc(`BTCL_OFS_STAT, 32'h10);
      wr(12'h020, 32'h5, `BTCL_RESP_SLVERR);
      rd(12'h020, rd_data, rd_resp);
      check(rd_resp, `BTCL_RESP_SLVERR);
      check(rd_data, 32'h0);
      wr(`BTCL_OFS_CMPA, 32'h0100, `BTCL_RESP_OKAY);
      wr(`BTCL_OFS_CMPB, 32'h02A5, `BTCL_RESP_OKAY);
      rdc(`BTCL_OFS_CMPB, 32'h02A5);
      wr(`BTCL_OFS_CTRL, 32'h65, `BTCL_RESP_OKAY);
      rdc(`BTCL_OFS_CTRL, 32'h65);
      pb(4'h0, 4'h0, 16'h0100, 8'h00, 1'b0, 1'b1, 1'b0);
      pb(4'h0, 4'h0, 16'h0101, 8'h00, 1'b0, 1'b0, 1'b0);
      pb(4'h0, 4'h4, 16'h0100, 8'h00, 1'b0, 1'b1, 1'b1);
      pb(4'h1, 4'h0, 16'h02A5, 8'h00, 1'b0, 1'b1, 1'b0);
      pb(4'h1, 4'h0, 16'h0100, 8'h00, 1'b0, 1'b1, 1'b0);
      pb(4'h1, 4'h0, 16'h0300, 8'h00, 1'b0, 1'b0, 1'b0);
      pb(4'h7, 4'h0, 16'h0100, 8'hA5, 1'b0, 1'b1, 1'b0);
      pb(4'h7, 4'h0, 16'h0100, 8'hA4, 1'b0, 1'b0, 1'b0);
      pb(4'h7, 4'h0, 16'h0101, 8'hA5, 1'b0, 1'b0, 1'b0);
      pb(4'h7, 4'h3, 16'h0100, 8'hA5, 1'b1, 1'b1, 1'b0);
      pb(4'h7, 4'h3, 16'h0100, 8'hA5, 1'b0, 1'b0, 1'b0);
      pb(4'h8, 4'h0, 16'h0100, 8'hA4, 1'b0, 1'b1, 1'b0);
      pb(4'h8, 4'h0, 16'h0100, 8'hA5, 1'b0, 1'b0, 1'b0);
      pb(4'h8, 4'h1, 16'h0100, 8'hA4, 1'b1, 1'b0, 1'b0);
      pb(4'h8, 4'h1, 16'h0100, 8'hA4, 1'b0, 1'b1, 1'b0);
      pb(4'h7, 4'hC, 16'h0100, 8'hA4, 1'b0, 1'b0, 1'b1);
      pb(4'h7, 4'hC, 16'h0100, 8'hA5, 1'b0, 1'b1, 1'b1);
      pb(4'h8, 4'hC, 16'h0100, 8'hA5, 1'b0, 1'b0, 1'b1);
      pb(4'h8, 4'hC, 16'h0101, 8'hA4, 1'b0, 1'b0, 1'b0);
      pb(4'h5, 4'h0, 16'h00FF, 8'h00, 1'b0, 1'b0, 1'b0);
      pb(4'h5, 4'h0, 16'h0100, 8'h00, 1'b0, 1'b1, 1'b0);
      pb(4'h5, 4'h0, 16'h02A5, 8'h00, 1'b0, 1'b1, 1'b0);
      pb(4'h5, 4'h0, 16'h02A6, 8'h00, 1'b0, 1'b0, 1'b0);
      pb(4'h6, 4'h0, 16'h00FF, 8'h00, 1'b0, 1'b1, 1'b0);
      pb(4'h6, 4'h0, 16'h0100, 8'h00, 1'b0, 1'b0, 1'b0);
      pb(4'h6, 4'h0, 16'h02A5, 8'h00, 1'b0, 1'b0, 1'b0);
      pb(4'h6, 4'h0, 16'h02A6, 8'h00, 1'b0, 1'b1, 1'b0);
      pb(4'h9, 4'h0, 16'h0100, 8'h00, 1'b0, 1'b0, 1'b0);
      pb(4'hF, 4'h0, 16'h02A5, 8'h00, 1'b0, 1'b0, 1'b0);
      wr(`BTCL_OFS_CTRL, 32'h102, `BTCL_RESP_OKAY);
      cyc(16'h02A5, 8'h00, 1'b0, 1'b0, 1'b0);
      cyc(16'h0100, 8'h00, 1'b0, 1'b0, 1'b0);
      cyc(16'h0123, 8'h00, 1'b0, 1'b0, 1'b0);
      cyc(16'h02A5, 8'h00, 1'b0, 1'b1, 1'b0);
      wr(`BTCL_OFS_CTRL, 32'h103, `BTCL_RESP_OKAY);
      cyc(16'h0100, 8'h11, 1'b0, 1'b0, 1'b0);
      for (i = 0; i < 8; i++) begin
         cyc(16'h02A5, 8'(8'h30 + i), 1'b0, 1'b1, 1'b0);
      end
      repeat (2) @(posedge aclk);
      #1;
      check(run_active, 1'b0);
      rdc(`BTCL_OFS_STAT, 32'h82C);
      for (i = 0; i < 8; i++) begin
         rd(`BTCL_OFS_FIFO, rd_data, rd_resp);
         check(rd_data[8:0], {1'b0, 8'(8'h30 + i)});
      end
      rd(`BTCL_OFS_FIFO, rd_data, rd_resp);
      check(rd_data[8], 1'b1);
      wr(`BTCL_OFS_CTRL, 32'h104, `BTCL_RESP_OKAY);
      cyc(16'h02A5, 8'h41, 1'b0, 1'b0, 1'b0);
      cyc(16'h0100, 8'h42, 1'b0, 1'b0, 1'b0);
      cyc(16'h02A5, 8'h43, 1'b0, 1'b1, 1'b0);
      cyc(16'h0100, 8'h44, 1'b0, 1'b0, 1'b0);
      cyc(16'h02A5, 8'h45, 1'b0, 1'b1, 1'b0);
      check(run_active, 1'b1);
      rd(`BTCL_OFS_FIFO, rd_data, rd_resp);
      check(rd_data[8:0], 9'h043);
      rd(`BTCL_OFS_FIFO, rd_data, rd_resp);
      check(rd_data[8:0], 9'h045);
      rd(`BTCL_OFS_FIFO, rd_data, rd_resp);
      check(rd_data[8], 1'b1);
      end_of_test;
   end
endmodule
